// ==== src/osc_map_mem.sv ====
// Purpose: byte memory holding the host-writable settings
// Assumes: read data one cycle after the address
// Notes: flip-flop array so a module reset can restore defaults at once
`timescale 1ns/10ps
`default_nettype none
module osc_map_mem
	import osc_pkg::*;
#(
	parameter int unsigned DEPTH = MAP_DEPTH
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	// access port
	osc_mem_if.mem bus
);
	logic [7:0] mem_ff [DEPTH];
	logic [7:0] rd_data_ff;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= MAP_RESET_VAL;
			end
		end else if (clk_en) begin
			if (bus.clear) begin
				for (int i = 0; i < DEPTH; i++) begin
					mem_ff[i] <= MAP_RESET_VAL;
				end
			end else if (bus.wr_en) begin
				mem_ff[bus.wr_addr] <= bus.wr_data;
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data_ff <= MAP_RESET_VAL;
		end else if (clk_en) begin
			rd_data_ff <= mem_ff[bus.rd_addr];
		end
	end

	assign bus.rd_data = rd_data_ff;
endmodule : osc_map_mem
`default_nettype wire

// ==== src/osc_mem_if.sv ====
// Purpose: carrier between the bus engine and the map memory
// Assumes: one write port, one registered read port
// Notes: clear restores every byte to its default
`timescale 1ns/10ps
`default_nettype none
interface osc_mem_if #(parameter int unsigned AW = 4);
	logic wr_en;
	logic clear;
	logic [AW-1:0] wr_addr;
	logic [AW-1:0] rd_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	modport ctrl(output wr_en, clear, wr_addr, rd_addr, wr_data, input rd_data);
	modport mem(input wr_en, clear, wr_addr, rd_addr, wr_data, output rd_data);
endinterface : osc_mem_if
`default_nettype wire

// ==== src/osc_pkg.sv ====
// Purpose: shared constants and types for the optical module sideband control
// Assumes: 10 MHz system clock; all management pins sampled by that clock
// Notes: the memory map is a small byte space reached over the two-wire bus
package osc_pkg;
	// timing
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned INIT_TIME_MS = 2000;
	localparam int unsigned INIT_CYCLES = INIT_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned RST_MIN_CYCLES = 16;
	// bus addressing
	localparam logic [6:0] DEV_ADDR = 7'h50;
	localparam int unsigned MAP_AW = 4;
	localparam int unsigned MAP_DEPTH = 16;
	localparam logic [3:0] OFS_STATUS = 4'h0;
	localparam logic [3:0] OFS_FLAGS = 4'h1;
	localparam logic [7:0] MAP_RESET_VAL = 8'h00;
	// fields
	localparam int unsigned STAT_NOT_READY_BIT = 0;
	localparam int unsigned FLAG_RST_DONE_BIT = 0;
	localparam int unsigned FLAG_FAULT_BIT = 1;
	localparam int unsigned FLAG_W = 2;
	// synchronised pin vector layout and idle levels
	localparam int unsigned IN_SEL = 0;
	localparam int unsigned IN_RST = 1;
	localparam int unsigned IN_LP = 2;
	localparam int unsigned IN_SCL = 3;
	localparam int unsigned IN_SDA = 4;
	localparam int unsigned IN_N = 5;
	localparam logic [4:0] PIN_IDLE = 5'h1B;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WR = 3'b011,
		ST_WR_ACK = 3'b100,
		ST_RD = 3'b101,
		ST_RD_ACK = 3'b110
	} osc_state_t;
endpackage : osc_pkg

// ==== src/osc_top.sv ====
// Purpose: sideband management logic inside a four-lane pluggable module
// Assumes: host drives select, reset, low power and the bus clock
// Notes: open-drain pins come out as out/oe pairs; the bench resolves wires
`timescale 1ns/10ps
`default_nettype none
module osc_top
	import osc_pkg::*;
#(
	parameter int unsigned INIT_CNT = INIT_CYCLES,
	parameter int unsigned RST_MIN = RST_MIN_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	// host control pins
	input wire logic module_select_n,
	input wire logic module_reset_n,
	input wire logic low_power_select,
	// two-wire bus
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// module status pins
	output logic presence_n_out,
	output logic presence_n_oe,
	output logic interrupt_n_out,
	output logic interrupt_n_oe,
	// internal side
	input wire logic fault_event,
	output logic power_limit,
	output logic module_ready
);
	localparam int unsigned RCW = $clog2(RST_MIN + 1);

	logic [IN_N-1:0] s1_ff, s2_ff, s3_ff, pin_ff, prev_ff;
	logic scl_rise, scl_fall, bus_start, bus_stop, selected;
	logic [RCW-1:0] rst_cnt_ff;
	logic hold_ff, not_ready_ff, init_fire;
	logic [31:0] init_cnt_ff;
	logic [FLAG_W-1:0] flags_ff, flag_set, flag_clr;
	osc_state_t state_ff;
	logic [7:0] shift_ff, rd_byte;
	logic [2:0] bit_cnt_ff;
	logic full_ff, ptr_set_ff, rw_ff, host_ack_ff;
	logic [MAP_AW-1:0] ptr_ff;
	logic sda_oe_ff, sda_out_ff, int_oe_ff, int_out_ff, prs_oe_ff, prs_out_ff;
	logic lp_ff, ready_ff, wr_en_ff, flags_rd_ff;
	logic [7:0] wr_data_ff;

	osc_mem_if #(.AW(MAP_AW)) mem_bus ();

	osc_map_mem #(.DEPTH(MAP_DEPTH)) u_mem (
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.bus(mem_bus)
	);

	// three-stage sampling of all five control signals' inputs
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s1_ff <= PIN_IDLE;
			s2_ff <= PIN_IDLE;
			s3_ff <= PIN_IDLE;
			pin_ff <= PIN_IDLE;
			prev_ff <= PIN_IDLE;
		end else if (clk_en) begin
			s1_ff <= {sda_in, scl, low_power_select, module_reset_n, module_select_n};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			// a level counts only once stages two and three agree
			pin_ff <= (s3_ff & ~(s2_ff ^ s3_ff)) | (pin_ff & (s2_ff ^ s3_ff));
			prev_ff <= pin_ff;
		end
	end

	assign scl_rise = pin_ff[IN_SCL] & ~prev_ff[IN_SCL];
	assign scl_fall = ~pin_ff[IN_SCL] & prev_ff[IN_SCL];
	assign bus_start = pin_ff[IN_SCL] & prev_ff[IN_SCL] & prev_ff[IN_SDA] & ~pin_ff[IN_SDA];
	assign bus_stop = pin_ff[IN_SCL] & prev_ff[IN_SCL] & ~prev_ff[IN_SDA] & pin_ff[IN_SDA];
	assign selected = ~pin_ff[IN_SEL];

	// short glitches on reset are filtered; only a long low resets
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rst_cnt_ff <= '0;
			hold_ff <= 1'b0;
		end else if (clk_en) begin
			if (pin_ff[IN_RST]) begin
				rst_cnt_ff <= '0;
				hold_ff <= 1'b0;
			end else if (rst_cnt_ff < RCW'(RST_MIN)) begin
				rst_cnt_ff <= rst_cnt_ff + RCW'(1);
			end else begin
				hold_ff <= 1'b1;
			end
		end
	end

	// not-ready from power-up or module reset until the init time elapses
	assign init_fire = not_ready_ff & ~hold_ff & (init_cnt_ff == INIT_CNT - 1);

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			not_ready_ff <= 1'b1;
			init_cnt_ff <= '0;
		end else if (clk_en) begin
			if (hold_ff) begin
				not_ready_ff <= 1'b1;
				init_cnt_ff <= '0;
			end else if (init_fire) begin
				not_ready_ff <= 1'b0;
			end else if (not_ready_ff) begin
				init_cnt_ff <= init_cnt_ff + 32'h1;
			end
		end
	end

	// sticky causes; a set in the cycle of its clear wins
	assign flag_set = FLAG_W'({fault_event, init_fire});

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			flags_ff <= '0;
		end else if (clk_en) begin
			if (hold_ff) begin
				flags_ff <= '0;
			end else begin
				flags_ff <= (flags_ff & ~flag_clr) | flag_set;
			end
		end
	end

	// status pins: open drain, low means asserted
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			int_oe_ff <= 1'b0;
			int_out_ff <= 1'b0;
			prs_oe_ff <= 1'b1;
			prs_out_ff <= 1'b0;
			lp_ff <= 1'b0;
			ready_ff <= 1'b0;
		end else if (clk_en) begin
			int_oe_ff <= |flags_ff;
			int_out_ff <= 1'b0;
			prs_oe_ff <= 1'b1;
			prs_out_ff <= 1'b0;
			lp_ff <= pin_ff[IN_LP];
			ready_ff <= ~not_ready_ff;
		end
	end

	// map reads: status and cause bytes come from live logic
	always_comb begin
		if (ptr_ff == OFS_STATUS) begin
			rd_byte = 8'h00;
			rd_byte[STAT_NOT_READY_BIT] = not_ready_ff;
		end else if (ptr_ff == OFS_FLAGS) begin
			rd_byte = {{(8 - FLAG_W){1'b0}}, flags_ff};
		end else begin
			rd_byte = mem_bus.rd_data;
		end
	end

	// reading the cause byte clears every cause held one cycle after the byte is loaded
	assign flag_clr = flags_rd_ff ? flags_ff : '0;

	// two-wire slave; host owns the clock, both sides use data
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= ST_IDLE;
			shift_ff <= 8'h00;
			bit_cnt_ff <= 3'h0;
			full_ff <= 1'b0;
			ptr_set_ff <= 1'b0;
			rw_ff <= 1'b0;
			host_ack_ff <= 1'b0;
			ptr_ff <= '0;
			sda_oe_ff <= 1'b0;
			sda_out_ff <= 1'b0;
			wr_en_ff <= 1'b0;
			wr_data_ff <= 8'h00;
			flags_rd_ff <= 1'b0;
		end else if (clk_en) begin
			wr_en_ff <= 1'b0;
			flags_rd_ff <= 1'b0;
			if (hold_ff || !selected) begin
				// deselected: drop any transfer, release the line
				state_ff <= ST_IDLE;
				sda_oe_ff <= 1'b0;
				full_ff <= 1'b0;
			end else if (bus_start) begin
				state_ff <= ST_ADDR;
				bit_cnt_ff <= 3'h0;
				full_ff <= 1'b0;
				ptr_set_ff <= 1'b0;
				sda_oe_ff <= 1'b0;
			end else if (bus_stop) begin
				state_ff <= ST_IDLE;
				sda_oe_ff <= 1'b0;
			end else begin
				if (scl_rise && (state_ff == ST_ADDR || state_ff == ST_WR)) begin
					shift_ff <= {shift_ff[6:0], pin_ff[IN_SDA]};
					bit_cnt_ff <= bit_cnt_ff + 3'h1;
					full_ff <= (bit_cnt_ff == 3'h7);
				end
				if (scl_rise && state_ff == ST_RD_ACK) begin
					host_ack_ff <= ~pin_ff[IN_SDA];
				end
				case (state_ff)
					ST_ADDR: begin
						if (scl_fall && full_ff) begin
							full_ff <= 1'b0;
							if (shift_ff[7:1] == DEV_ADDR) begin
								rw_ff <= shift_ff[0];
								sda_oe_ff <= 1'b1;
								state_ff <= ST_ADDR_ACK;
							end else begin
								state_ff <= ST_IDLE;
							end
						end
					end
					ST_ADDR_ACK, ST_RD_ACK: begin
						if (scl_fall) begin
							if (state_ff == ST_RD_ACK && !host_ack_ff) begin
								sda_oe_ff <= 1'b0;
								state_ff <= ST_IDLE;
							end else if (state_ff == ST_RD_ACK || rw_ff) begin
								sda_oe_ff <= ~rd_byte[7];
								shift_ff <= {rd_byte[6:0], 1'b1};
								bit_cnt_ff <= 3'h0;
								flags_rd_ff <= (ptr_ff == OFS_FLAGS);
								state_ff <= ST_RD;
							end else begin
								sda_oe_ff <= 1'b0;
								bit_cnt_ff <= 3'h0;
								state_ff <= ST_WR;
							end
						end
					end
					ST_WR: begin
						if (scl_fall && full_ff) begin
							full_ff <= 1'b0;
							sda_oe_ff <= 1'b1;
							state_ff <= ST_WR_ACK;
							if (!ptr_set_ff) begin
								ptr_ff <= shift_ff[MAP_AW-1:0];
								ptr_set_ff <= 1'b1;
							end else begin
								wr_en_ff <= 1'b1;
								wr_data_ff <= shift_ff;
								ptr_ff <= ptr_ff + MAP_AW'(1);
							end
						end
					end
					ST_WR_ACK: begin
						if (scl_fall) begin
							sda_oe_ff <= 1'b0;
							state_ff <= ST_WR;
						end
					end
					ST_RD: begin
						if (scl_fall) begin
							if (bit_cnt_ff == 3'h7) begin
								sda_oe_ff <= 1'b0;
								ptr_ff <= ptr_ff + MAP_AW'(1);
								state_ff <= ST_RD_ACK;
							end else begin
								sda_oe_ff <= ~shift_ff[7];
								shift_ff <= {shift_ff[6:0], 1'b1};
								bit_cnt_ff <= bit_cnt_ff + 3'h1;
							end
						end
					end
					default: begin
						state_ff <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// write lands one cycle after the ack; pointer already advanced
	assign mem_bus.wr_en = wr_en_ff;
	assign mem_bus.wr_addr = ptr_ff - MAP_AW'(1);
	assign mem_bus.wr_data = wr_data_ff;
	assign mem_bus.rd_addr = ptr_ff;
	assign mem_bus.clear = hold_ff;

	assign sda_out = sda_out_ff;
	assign sda_oe = sda_oe_ff;
	assign presence_n_out = prs_out_ff;
	assign presence_n_oe = prs_oe_ff;
	assign interrupt_n_out = int_out_ff;
	assign interrupt_n_oe = int_oe_ff;
	assign power_limit = lp_ff;
	assign module_ready = ready_ff;

	chk_sel_release: assert property (@(posedge clock) disable iff (sys_rst)
		(clk_en && !selected) |=> (!sda_oe_ff && state_ff == ST_IDLE))
		else $error("bus driven while deselected");
	chk_reset_default: assert property (@(posedge clock) disable iff (sys_rst)
		(clk_en && hold_ff) |=> (not_ready_ff && flags_ff == '0 &&
		(!int_oe_ff || $past(flags_ff) != '0)))
		else $error("module reset did not restore defaults");
	chk_done_int: assert property (@(posedge clock) disable iff (sys_rst)
		(clk_en && init_fire) |=> (!not_ready_ff && flags_ff[FLAG_RST_DONE_BIT]))
		else $error("reset completion not posted");
	chk_done_pin: assert property (@(posedge clock) disable iff (sys_rst)
		$fell(not_ready_ff) && clk_en |=> int_oe_ff)
		else $error("completion interrupt not on pin");
	chk_lp_follow: assert property (@(posedge clock) disable iff (sys_rst)
		(clk_en && pin_ff[IN_LP]) |=> power_limit)
		else $error("low power request not applied");
	chk_presence_low: assert property (@(posedge clock) disable iff (sys_rst)
		presence_n_oe && !presence_n_out)
		else $error("presence not pulled low");
	chk_fault_int: assert property (@(posedge clock) disable iff (sys_rst)
		(clk_en && fault_event && !hold_ff) |=> clk_en [*1] |=> int_oe_ff)
		else $error("fault did not pull interrupt low");
	chk_init_bound: assert property (@(posedge clock) disable iff (sys_rst)
		init_cnt_ff < INIT_CNT)
		else $error("initialisation overran its time");
	chk_sda_od: assert property (@(posedge clock) disable iff (sys_rst)
		!sda_out_ff && (!sda_oe_ff || state_ff != ST_IDLE))
		else $error("data line driven outside a transfer");
endmodule : osc_top
`default_nettype wire

// ==== verification/osc_host_model.sv ====
// Purpose: host side of the two-wire management bus
// Assumes: data line resolved by the bench with a pull-up
// Notes: bus tasks are called by the bench; pins move just after clock edges
`timescale 1ns/10ps
`default_nettype none
module osc_host_model
	import osc_pkg::*;
(
	// system clock
	input wire logic clock,
	// bus pins
	input wire logic sda,
	output var logic scl = 1'h1,
	output var logic sda_pull = 1'h0,
	output var logic select_n = 1'h1
);
	// 800 ns period; low phase six cycles since the answer lags a falling edge by five
	localparam int LO = 6;
	localparam int HI = 2;
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic bit_io(input logic b, output logic r);
		tick(1);
		sda_pull <= ~b;
		tick(LO - 1);
		scl <= 1'h1;
		tick(1);
		r = sda;
		tick(HI - 1);
		scl <= 1'h0;
	endtask : bit_io
	// also serves as a repeated start from a low clock
	task automatic start_cond();
		tick(1);
		sda_pull <= 1'h0;
		tick(LO - 1);
		scl <= 1'h1;
		tick(4);
		sda_pull <= 1'h1;
		tick(4);
		scl <= 1'h0;
	endtask : start_cond
	// trailing tick keeps select from being driven twice in one step
	task automatic stop_cond();
		tick(1);
		sda_pull <= 1'h1;
		tick(LO - 1);
		scl <= 1'h1;
		tick(4);
		sda_pull <= 1'h0;
		tick(4);
		select_n <= 1'h1;
		tick(1);
	endtask : stop_cond
	task automatic put_byte(input logic [7:0] d, inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'h1, r);
		ok = ok & ~r;
	endtask : put_byte
	task automatic get_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'h1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask : get_byte
	task automatic write_two(input logic sel, input logic [6:0] adr, input logic [3:0] ptr,
		input logic [15:0] d, output logic ok);
		ok = 1'h1;
		select_n <= ~sel;
		start_cond();
		put_byte({adr, 1'h0}, ok);
		put_byte({4'h0, ptr}, ok);
		put_byte(d[15:8], ok);
		put_byte(d[7:0], ok);
		stop_cond();
	endtask : write_two
	task automatic read_two(input logic [3:0] ptr, output logic [15:0] d, output logic ok);
		ok = 1'h1;
		select_n <= 1'h0;
		start_cond();
		put_byte({DEV_ADDR, 1'h0}, ok);
		put_byte({4'h0, ptr}, ok);
		start_cond();
		put_byte({DEV_ADDR, 1'h1}, ok);
		get_byte(1'h0, d[15:8]);
		get_byte(1'h1, d[7:0]);
		stop_cond();
	endtask : read_two
endmodule : osc_host_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Purpose: self-checking bench for the sideband control block
// Assumes: shortened init and reset counts through the top parameters
// Notes: random data from a fixed seed plus hand-picked corners
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import osc_pkg::*;
	localparam int unsigned INIT_SIM = 50;
	localparam int unsigned RST_SIM = 4;
	logic clock = 1'h0;
	logic sys_rst = 1'h1;
	logic clk_en = 1'h1;
	logic module_reset_n = 1'h1;
	logic low_power_select = 1'h0;
	logic fault_event = 1'h0;
	logic scl, sda_pull, select_n, sda_oe, sda_out;
	logic presence_n_out, presence_n_oe, interrupt_n_out, interrupt_n_oe;
	logic power_limit, module_ready;
	wire logic sda_line;
	int miscompares = 0;
	int total_checks = 0;
	int seed = 76477;
	logic ok;
	logic [15:0] rd;
	logic [15:0] wd;
	logic [3:0] ptr;
	// pull-up: a released line reads high
	assign sda_line = ~((sda_oe & ~sda_out) | sda_pull);
	always #50 clock = ~clock;
	osc_top #(.INIT_CNT(INIT_SIM), .RST_MIN(RST_SIM)) osc_top_inst (
		.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
		.module_select_n(select_n), .module_reset_n(module_reset_n),
		.low_power_select(low_power_select), .scl(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .presence_n_out(presence_n_out),
		.presence_n_oe(presence_n_oe), .interrupt_n_out(interrupt_n_out),
		.interrupt_n_oe(interrupt_n_oe), .fault_event(fault_event),
		.power_limit(power_limit), .module_ready(module_ready)
	);
	osc_host_model host_inst (
		.clock(clock), .sda(sda_line), .scl(scl), .sda_pull(sda_pull), .select_n(select_n)
	);
	// status byte first, cause byte second
	function automatic logic [15:0] status_cause(input logic done, input logic fault);
		logic [15:0] v;
		v = 16'h0000;
		v[FLAG_RST_DONE_BIT] = done;
		v[FLAG_FAULT_BIT] = fault;
		return v;
	endfunction : status_cause
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude
	// which high waits for ready, low for the interrupt
	task automatic wait_up(input logic which, input int limit);
		int n;
		n = 0;
		while ((which ? module_ready : interrupt_n_oe) !== 1'h1) begin
			@(negedge clock);
			n++;
			if (n > limit) begin
				check(16'h0, 16'h1, "wait bound");
				conclude();
			end
		end
	endtask : wait_up
	initial begin
		repeat (100000) @(posedge clock);
		check(16'h0, 16'h1, "run time");
		conclude();
	end
	initial begin
		repeat (10) @(posedge clock);
		sys_rst <= 1'h0;
		check({14'h0, presence_n_oe, presence_n_out}, 16'h2, "presence");
		wait_up(1'h1, INIT_SIM + 20);
		wait_up(1'h0, 10);
		check({15'h0, interrupt_n_out}, 16'h0, "int level");
		host_inst.read_two(OFS_STATUS, rd, ok);
		check(rd, status_cause(1'h1, 1'h0), "power-up");
		@(negedge clock);
		check({15'h0, interrupt_n_oe}, 16'h0, "int cleared");
		for (int i = 0; i < 5; i++) begin
			@(posedge clock);
			ptr = (i == 4) ? 4'hE : 4'h2 + 4'($unsigned($random(seed)) % 12);
			wd = 16'($random(seed));
			low_power_select <= 1'($random(seed));
			host_inst.write_two(1'h1, DEV_ADDR, ptr, wd, ok);
			check({15'h0, ok}, 16'h1, "write ack");
			host_inst.read_two(ptr, rd, ok);
			check(rd, wd, "readback");
			check({15'h0, power_limit}, {15'h0, low_power_select}, "power");
		end
		host_inst.write_two(1'h0, DEV_ADDR, ptr, ~wd, ok);
		check({15'h0, ok}, 16'h0, "unselected");
		host_inst.write_two(1'h1, DEV_ADDR ^ 7'h01, ptr, ~wd, ok);
		check({15'h0, ok}, 16'h0, "foreign address");
		host_inst.read_two(ptr, rd, ok);
		check(rd, wd, "untouched");
		@(posedge clock);
		fault_event <= 1'h1;
		@(posedge clock);
		fault_event <= 1'h0;
		repeat (3) @(negedge clock);
		check({15'h0, interrupt_n_oe}, 16'h1, "fault int");
		host_inst.read_two(OFS_STATUS, rd, ok);
		check(rd, status_cause(1'h0, 1'h1), "fault cause");
		@(posedge clock);
		module_reset_n <= 1'h0;
		repeat (RST_SIM + 12) @(posedge clock);
		module_reset_n <= 1'h1;
		clk_en <= 1'h0;
		@(negedge clock);
		check({15'h0, module_ready}, 16'h0, "held");
		// frozen longer than a full init: ready must not appear
		repeat (INIT_SIM + 20) @(posedge clock);
		check({15'h0, module_ready}, 16'h0, "frozen");
		clk_en <= 1'h1;
		wait_up(1'h1, INIT_SIM + 20);
		wait_up(1'h0, 10);
		host_inst.read_two(ptr, rd, ok);
		check(rd, 16'h0000, "defaults");
		host_inst.read_two(OFS_STATUS, rd, ok);
		check(rd, status_cause(1'h1, 1'h0), "reset done");
		conclude();
	end
endmodule : testbench
`default_nettype wire
